/* File: pkg/iaw_pkg.sv */
// Constants and carriers for the indirect access / wake-event block.
// Assumes one byte-wide register port and a 250 MHz core clock.
package iaw_pkg;

	// Byte register addresses seen by the host
	localparam logic [7:0] IAW_ADDR_SEL   = 8'h6e; // Selection, 110
	localparam logic [7:0] IAW_ADDR_OFS   = 8'h6f; // Offset/trigger, 111
	localparam logic [7:0] IAW_ADDR_ENT0  = 8'h70; // Entry bits 71:64, 112
	localparam logic [7:0] IAW_ADDR_ENTN  = 8'h78; // Entry bits 7:0, 120
	localparam logic [7:0] IAW_ADDR_DATA  = 8'ha0; // Data window, 160

	// Selection register fields
	localparam int         IAW_SEL_SPACE_HI = 7;
	localparam int         IAW_SEL_SPACE_LO = 5;
	localparam int         IAW_SEL_RD_BIT   = 4;
	localparam logic [2:0] IAW_SPACE_WAKE   = 3'h4;
	localparam logic [5:0] IAW_SEL_TBL_RD   = 6'h06; // Bits 7:2 of 0x18
	localparam logic [7:0] IAW_SEL_RST      = 8'h00;
	localparam logic [7:0] IAW_OFS_RST      = 8'h00;

	// Wake-event register layout inside the offset space
	localparam logic [1:0] IAW_LOW_LANE     = 2'h3; // Offset 0x03 / 0x07
	localparam int         IAW_OFS_MASK_BIT = 2;    // Set for 0x04..0x07
	localparam int         IAW_CTRL_EN_BIT  = 1;
	localparam int         IAW_CTRL_POL_BIT = 0;
	localparam logic [1:0] IAW_CTRL_RST     = 2'h0;
	localparam int         IAW_PORTS        = 4;
	localparam logic       IAW_WAKE_O_RST   = 1'b1; // Active-low, idle

	// Table entry geometry
	localparam int         IAW_ENT_BYTES    = 9;
	localparam int         IAW_IDX_W        = 10;

	// Detect flags, masks and event inputs share one layout
	typedef struct packed {
		logic frame;   // Wake frame, bit 2
		logic link;    // Link-up, bit 1
		logic energy;  // Line energy, bit 0
	} iaw_ev_t;

	localparam iaw_ev_t    IAW_EV_RST = '{frame: 1'b0, link: 1'b0,
		energy: 1'b0};

	// Learned address table entry, bit 71 down to bit 0
	typedef struct packed {
		logic        table_empty; // 71
		logic [9:0]  valid_cnt;   // 70:61
		logic [1:0]  age_stamp;   // 60:59
		logic [2:0]  src_port;    // 58:56
		logic        not_ready;   // 55
		logic [6:0]  filter_id;   // 54:48
		logic [47:0] station;     // 47:0
	} iaw_entry_t;

	localparam iaw_entry_t IAW_ENTRY_RST = '{table_empty: 1'b1,
		valid_cnt: 10'h000, age_stamp: 2'h0, src_port: 3'h0,
		not_ready: 1'b0, filter_id: 7'h00, station: 48'h0};

endpackage : iaw_pkg

/* File: rtl/iaw_indirect_wake.sv */
// Indirect register access port: learned-table reads and wake-event block.
// Assumes a synchronous byte register port driven by the host logic,
// a table engine that answers one request with one ack, and event
// inputs that are one-cycle pulses in the core clock domain.
//
// Notes on behaviour
// - Entry index is selection low bits, offset
// - Entry bytes 71:64 at 112 down to 120
// - First two entry bytes carry valid count
// - Selection 100 picks wake space, port bits
// - Global bit 1 enables wake output
// - Global bit 0 sets wake output polarity
// - Port flags: frame, link-up, energy
// - Flags stay set until written one
// - Mask bit 2 gates wake frame
// - Mask bit 1 gates link-up
// - Mask bit 0 gates energy detect
// - Offset write starts the indirect read
// - Entry fields: empty, count, port, id, address
module iaw_indirect_wake
	import iaw_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	output logic      [7:0]            reg_rdata_o,
	output logic                       tbl_req_o,
	output logic      [IAW_IDX_W-1:0]  tbl_idx_o,
	input  wire logic                  tbl_ack_i,
	input  wire iaw_entry_t            tbl_entry_i,
	input  wire iaw_ev_t [IAW_PORTS-1:0] wake_ev_i,
	output logic                       wake_o
);

	// Byte lane of a 32-bit word, offset 0 is the top byte
	function automatic logic [7:0] word_byte(
		input logic [31:0] w,
		input logic [1:0]  lane
	);
		logic [7:0] b;
		b = 8'h00;
		case (lane)
			2'h0: b = w[31:24];
			2'h1: b = w[23:16];
			2'h2: b = w[15:8];
			default: b = w[7:0];
		endcase
		return b;
	endfunction : word_byte

	// Entry byte by register distance from the first entry byte
	function automatic logic [7:0] entry_byte(
		input iaw_entry_t e,
		input logic [3:0] pos
	);
		logic [71:0] flat;
		logic [7:0]  b;
		flat = e;
		b    = 8'h00;
		case (pos)
			4'h0: b = flat[71:64];
			4'h1: b = flat[63:56];
			4'h2: b = flat[55:48];
			4'h3: b = flat[47:40];
			4'h4: b = flat[39:32];
			4'h5: b = flat[31:24];
			4'h6: b = flat[23:16];
			4'h7: b = flat[15:8];
			4'h8: b = flat[7:0];
			default: b = 8'h00;
		endcase
		return b;
	endfunction : entry_byte

	// State
	logic [7:0]           sel_r;
	logic [7:0]           ofs_r;
	logic [7:0]           data_r;
	logic [7:0]           rdata_r;
	logic [1:0]           ctrl_r;
	iaw_ev_t              st_r   [IAW_PORTS];
	iaw_ev_t              mask_r [IAW_PORTS];
	iaw_ev_t              st_nxt [IAW_PORTS];
	iaw_entry_t           entry_r;
	logic                 pend_r;
	logic                 req_r;
	logic [IAW_IDX_W-1:0] idx_r;
	logic                 wake_r;

	// Host access decode
	wire wr_sel  = reg_wr_i && (reg_addr_i == IAW_ADDR_SEL);
	wire wr_ofs  = reg_wr_i && (reg_addr_i == IAW_ADDR_OFS);
	wire wr_data = reg_wr_i && (reg_addr_i == IAW_ADDR_DATA);

	// Selection fields
	wire [2:0] sel_space = sel_r[IAW_SEL_SPACE_HI:IAW_SEL_SPACE_LO];
	wire       sel_rd    = sel_r[IAW_SEL_RD_BIT];
	wire [3:0] sel_port  = sel_r[3:0];
	wire       is_wake   = (sel_space == IAW_SPACE_WAKE);
	wire       is_tbl    = (sel_r[7:2] == IAW_SEL_TBL_RD);
	wire       port_glb  = (sel_port == 4'h0);
	wire       port_ok   = (sel_port >= 4'h1) &&
		(sel_port <= 4'(IAW_PORTS));
	wire [1:0] port_idx  = 2'(sel_port - 4'h1);

	// Trigger events on the offset write
	wire tbl_go = wr_ofs && is_tbl;
	wire wk_go  = wr_ofs && is_wake && sel_rd;
	wire [IAW_IDX_W-1:0] go_idx = {sel_r[1:0], reg_wdata_i};

	// Wake word addressed by selection and the new offset
	wire        new_mask = reg_wdata_i[IAW_OFS_MASK_BIT];
	wire        new_inrg = (reg_wdata_i[7:3] == 5'h00);
	wire [31:0] ctrl_w   = {30'h0, ctrl_r};
	wire [31:0] st_w     = {29'h0, st_r[port_idx]};
	wire [31:0] mask_w   = {29'h0, mask_r[port_idx]};
	wire [31:0] glb_w    = new_mask ? 32'h0 : ctrl_w;
	wire [31:0] prt_w    = new_mask ? mask_w : st_w;
	wire [31:0] wk_word  = port_glb ? glb_w :
		(port_ok ? prt_w : 32'h0);
	wire [7:0]  wk_byte  = new_inrg ?
		word_byte(wk_word, reg_wdata_i[1:0]) : 8'h00;

	// Writes land only in the low byte; upper bits are reserved
	wire wk_wr    = wr_data && is_wake && !sel_rd;
	wire low_lane = (ofs_r[7:3] == 5'h00) &&
		(ofs_r[1:0] == IAW_LOW_LANE);
	wire ofs_mask = ofs_r[IAW_OFS_MASK_BIT];
	wire ctrl_we  = wk_wr && port_glb && low_lane && !ofs_mask;
	wire st_we    = wk_wr && port_ok && low_lane && !ofs_mask;
	wire mask_we  = wk_wr && port_ok && low_lane && ofs_mask;
	wire iaw_ev_t wdata_ev = reg_wdata_i[2:0];

	// Read mux for the byte port; unmapped addresses read zero
	wire       rd_ent   = (reg_addr_i >= IAW_ADDR_ENT0) &&
		(reg_addr_i <= IAW_ADDR_ENTN);
	wire [3:0] ent_pos  = 4'(reg_addr_i - IAW_ADDR_ENT0);
	wire [7:0] rd_mux   =
		(reg_addr_i == IAW_ADDR_SEL)  ? sel_r :
		(reg_addr_i == IAW_ADDR_OFS)  ? ofs_r :
		(reg_addr_i == IAW_ADDR_DATA) ? data_r :
		rd_ent ? entry_byte(entry_r, ent_pos) : 8'h00;

	// Flag update: new event wins over a same-cycle clear
	genvar p;
	generate
		for (p = 0; p < IAW_PORTS; p++)
		begin : g_flag
			wire     hit = st_we && (port_idx == 2'(p));
			wire iaw_ev_t clr = hit ? wdata_ev : IAW_EV_RST;
			assign st_nxt[p] = (st_r[p] & ~clr) | wake_ev_i[p];
		end
	endgenerate

	// Any port with a flag whose mask bit is set
	logic wake_any;
	always_comb
	begin
		wake_any = 1'b0;
		for (int i = 0; i < IAW_PORTS; i++)
		begin
			wake_any = wake_any | (|(st_r[i] & mask_r[i]));
		end
	end

	// Level after enable, then shaped by polarity
	wire wake_lvl = ctrl_r[IAW_CTRL_EN_BIT] && wake_any;
	wire wake_nxt = ctrl_r[IAW_CTRL_POL_BIT] ? wake_lvl
		: !wake_lvl;

	// Selection and offset registers
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			sel_r <= IAW_SEL_RST;
			ofs_r <= IAW_OFS_RST;
		end
		else
		begin
			if (wr_sel)
				sel_r <= reg_wdata_i;
			if (wr_ofs)
				ofs_r <= reg_wdata_i;
		end
	end

	// Data window: latched read byte or last written byte
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			data_r <= 8'h00;
		else if (wk_go)
			data_r <= wk_byte;
		else if (wr_data)
			data_r <= reg_wdata_i;
	end

	// Global control bits
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			ctrl_r <= IAW_CTRL_RST;
		else if (ctrl_we)
			ctrl_r <= reg_wdata_i[1:0];
	end

	// Per-port detect flags and masks
	always_ff @(posedge clk_i)
	begin
		for (int i = 0; i < IAW_PORTS; i++)
		begin
			if (srst_i)
			begin
				st_r[i]   <= IAW_EV_RST;
				mask_r[i] <= IAW_EV_RST;
			end
			else
			begin
				st_r[i] <= st_nxt[i];
				if (mask_we && (port_idx == 2'(i)))
					mask_r[i] <= wdata_ev;
			end
		end
	end

	// Table request: entry shows not-ready until the engine answers.
	// A new trigger while one is pending restarts; the next ack wins.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			entry_r <= IAW_ENTRY_RST;
			pend_r  <= 1'b0;
			req_r   <= 1'b0;
			idx_r   <= '0;
		end
		else
		begin
			req_r <= tbl_go;
			if (tbl_go)
			begin
				pend_r            <= 1'b1;
				idx_r             <= go_idx;
				entry_r.not_ready <= 1'b1;
			end
			else if (pend_r && tbl_ack_i)
			begin
				pend_r  <= 1'b0;
				entry_r <= tbl_entry_i;
			end
		end
	end

	// Read data one cycle after the read strobe
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_r <= 8'h00;
		else if (reg_rd_i)
			rdata_r <= rd_mux;
	end

	// Registered wake pin, inactive-high out of reset
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			wake_r <= IAW_WAKE_O_RST;
		else
			wake_r <= wake_nxt;
	end

	assign reg_rdata_o = rdata_r;
	assign tbl_req_o   = req_r;
	assign tbl_idx_o   = idx_r;
	assign wake_o      = wake_r;

endmodule : iaw_indirect_wake

/* File: sim/iaw_indirect_wake_sva.sv */
// Assertion checker for the indirect access / wake-event block.
// Sees only the top ports; bound onto every instance of the block.
module iaw_indirect_wake_sva
	import iaw_pkg::*;
(
	input wire logic                 clk_i,
	input wire logic                 srst_i,
	input wire logic                 reg_wr_i,
	input wire logic                 reg_rd_i,
	input wire logic [7:0]           reg_addr_i,
	input wire logic [7:0]           reg_wdata_i,
	input wire logic [7:0]           reg_rdata_o,
	input wire logic                 tbl_req_o,
	input wire logic [IAW_IDX_W-1:0] tbl_idx_o,
	input wire logic                 tbl_ack_i,
	input wire iaw_entry_t           tbl_entry_i,
	input wire logic                 wake_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	logic [7:0] sel_r;
	logic [7:0] ofs_r;
	logic [1:0] ctrl_r;
	logic       pend_r;
	iaw_entry_t ent_r;
	// Host access decodes
	wire logic       trig = reg_wr_i && reg_addr_i == IAW_ADDR_OFS
		&& sel_r[7:2] == IAW_SEL_TBL_RD;
	wire logic       snap = reg_wr_i && reg_addr_i == IAW_ADDR_OFS
		&& sel_r == 8'h90 && reg_wdata_i == 8'h03;
	wire logic       ent_rd = reg_rd_i && reg_addr_i >= IAW_ADDR_ENT0
		&& reg_addr_i <= IAW_ADDR_ENTN;
	wire logic [7:0] ent_b = ent_r[8 * (IAW_ADDR_ENTN - reg_addr_i) +: 8];

	// Shadow state; entry only trusted once no request is pending
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			sel_r  <= IAW_SEL_RST;
			ofs_r  <= IAW_OFS_RST;
			ctrl_r <= IAW_CTRL_RST;
			pend_r <= 1'b0;
			ent_r  <= IAW_ENTRY_RST;
		end
		else
		begin
			if (reg_wr_i && reg_addr_i == IAW_ADDR_SEL)
				sel_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == IAW_ADDR_OFS)
				ofs_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == IAW_ADDR_DATA && sel_r == 8'h80
				&& ofs_r == 8'h03)
				ctrl_r <= reg_wdata_i[1:0];
			pend_r <= tbl_req_o || (pend_r && !tbl_ack_i);
			if (tbl_ack_i && pend_r)
				ent_r <= tbl_entry_i;
		end
	end

	req_index_a: assert property (trig |=> tbl_req_o
		&& tbl_idx_o == $past({sel_r[1:0], reg_wdata_i}))
		else $error("table request or index wrong");
	req_only_a: assert property (!trig |=> !tbl_req_o)
		else $error("table request without trigger");
	idx_hold_a: assert property (!trig |=> $stable(tbl_idx_o))
		else $error("table index moved");
	rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	entry_byte_a: assert property (ent_rd && !pend_r && !tbl_req_o
		|=> reg_rdata_o == $past(ent_b)) else $error("entry byte wrong");
	not_ready_a: assert property (reg_rd_i && reg_addr_i == 8'h72
		&& (pend_r || tbl_req_o) && !tbl_ack_i |=> reg_rdata_o[7])
		else $error("pending entry shown ready");
	wake_off_a: assert property (!ctrl_r[IAW_CTRL_EN_BIT]
		|=> wake_o == !$past(ctrl_r[IAW_CTRL_POL_BIT]))
		else $error("wake pin active while disabled");
	ctrl_read_a: assert property (snap ##1 reg_rd_i
		&& reg_addr_i == IAW_ADDR_DATA |=> reg_rdata_o == {6'h00, $past(ctrl_r, 2)})
		else $error("global control read wrong");
endmodule : iaw_indirect_wake_sva

bind iaw_indirect_wake iaw_indirect_wake_sva i_sva (.clk_i, .srst_i,
	.reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
	.tbl_req_o, .tbl_idx_o, .tbl_ack_i, .tbl_entry_i, .wake_o);

/* File: sim/iaw_indirect_wake_tb_top.sv */
// Self-checking bench for the indirect access / wake-event block.
// Assumes the table model answers every request within 13 cycles.
module iaw_indirect_wake_tb_top import iaw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk_i, srst_i, reg_wr_i, reg_rd_i;
	logic [7:0]              reg_addr_i, reg_wdata_i, reg_rdata_o, v;
	logic                    tbl_req_o, tbl_ack_i, wake_o, pol;
	logic [IAW_IDX_W-1:0]    tbl_idx_o, ix;
	iaw_entry_t              tbl_entry_i, exp_ent;
	iaw_ev_t [IAW_PORTS-1:0] wake_ev_i;
	logic [3:0]              p;
	logic [31:0]             rng;
	int                      fail_count, n_compared, n;

	// Clock at 250 MHz
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	iaw_indirect_wake i_dut (.clk_i, .srst_i, .reg_wr_i, .reg_rd_i,
		.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .tbl_req_o, .tbl_idx_o,
		.tbl_ack_i, .tbl_entry_i, .wake_ev_i, .wake_o);
	iaw_tbl_model i_tbl (.clk_i, .srst_i, .req_i(tbl_req_o),
		.idx_i(tbl_idx_o), .ack_o(tbl_ack_i), .entry_o(tbl_entry_i));
	// Expected entry is what the engine handed over
	always @(posedge clk_i)
		if (tbl_ack_i)
			exp_ent <= tbl_entry_i;

	function logic [31:0] xs_next();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs_next
	function logic exp_wake(logic en, logic pl, logic act);
		return pl ? (en & act) : !(en & act);
	endfunction : exp_wake
	task chk(string nm, logic [9:0] e, logic [9:0] g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Strobes drop on the falling edge after the sampling edge
	task wr_b(logic [7:0] a, logic [7:0] d);
		@(negedge clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(posedge clk_i);
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask : wr_b
	task rd_b(logic [7:0] a);
		@(negedge clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(posedge clk_i);
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		v = reg_rdata_o;
	endtask : rd_b
	task sel2(logic [7:0] s, logic [7:0] o);
		wr_b(IAW_ADDR_SEL, s);
		wr_b(IAW_ADDR_OFS, o);
	endtask : sel2
	task report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// Main sequence: reset, table reads, wake sources
	initial
	begin
		{srst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 19'h40000;
		wake_ev_i = '0;
		rng = 32'h6569;
		repeat (12) @(negedge clk_i);
		srst_i = 1'b0;
		chk("wake pin", 1, wake_o);
		rd_b(IAW_ADDR_ENT0);
		chk("entry byte", 8'h80, v);
		sel2(8'h90, 8'h03);
		rd_b(IAW_ADDR_DATA);
		chk("global control", 0, v);
		$display("reset test done");
		for (int t = 0; t < 6; t++)
		begin
			ix = t == 0 ? 10'h000 : t == 1 ? 10'h101 : xs_next();
			sel2({6'h06, ix[9:8]}, ix[7:0]);
			@(negedge clk_i);
			chk("index", ix, tbl_idx_o);
			n = 0;
			do begin rd_b(8'h72); n++; end while (v[7] && n < 40);
			chk("entry byte", exp_ent[55:48], v);
			if (v[7])
				report_and_stop();
			for (int b = 0; b < 9; b++)
				if (b != 2 && (b > 1 || t != 1))
				begin
					rd_b(IAW_ADDR_ENT0 + 8'(b));
					chk("entry byte", exp_ent[71 - 8 * b -: 8], v);
				end
			$display("table read %0d done", ix);
		end
		for (int k = 0; k < 3; k++)
		begin
			p = 4'(xs_next() % 4) + 4'h1;
			pol = k[0];
			sel2(8'h80, 8'h03);
			wr_b(IAW_ADDR_DATA, {6'h00, 1'b1, pol});
			sel2({4'h8, p}, 8'h07);
			wr_b(IAW_ADDR_DATA, 8'h07 ^ (8'h01 << k));
			@(negedge clk_i);
			wake_ev_i[p - 4'h1] = iaw_ev_t'(3'h1 << k);
			@(negedge clk_i);
			wake_ev_i = '0;
			repeat (2) @(negedge clk_i);
			chk("wake masked", exp_wake(1, pol, 0), wake_o);
			sel2({4'h9, p}, 8'h03);
			rd_b(IAW_ADDR_DATA);
			chk("status", 8'h01 << k, v);
			sel2({4'h8, p}, 8'h07);
			wr_b(IAW_ADDR_DATA, 8'h07);
			repeat (2) @(negedge clk_i);
			chk("wake on", exp_wake(1, pol, 1), wake_o);
			sel2({4'h9, p}, 8'h07);
			rd_b(IAW_ADDR_DATA);
			chk("mask", 8'h07, v);
			sel2(8'h80, 8'h03);
			wr_b(IAW_ADDR_DATA, {7'h00, pol});
			repeat (2) @(negedge clk_i);
			chk("wake off", exp_wake(0, pol, 1), wake_o);
			sel2({4'h8, p}, 8'h03);
			wr_b(IAW_ADDR_DATA, 8'h01 << k);
			sel2({4'h9, p}, 8'h03);
			rd_b(IAW_ADDR_DATA);
			chk("status", 0, v);
			$display("wake source %0d done", k);
		end
		report_and_stop();
	end
endmodule : iaw_indirect_wake_tb_top

/* File: sim/iaw_tbl_model.sv */
// Behavioural learned-table engine on the far side of the table link.
// Assumes one request at a time; answer delay follows the index.
module iaw_tbl_model
	import iaw_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 srst_i,
	input  wire logic                 req_i,
	input  wire logic [IAW_IDX_W-1:0] idx_i,
	output logic                      ack_o,
	output iaw_entry_t                entry_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]           wait_r;
	logic [IAW_IDX_W-1:0] idx_r;
	logic                 busy_r;
	// Prompt for index 0 mod 4, slow up to 13 cycles otherwise
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		entry_o <= ~entry_o; // Lines not held between answers
		if (srst_i)
		begin
			busy_r <= 1'b0;
			entry_o <= '0;
		end
		else if (req_i)
		begin
			busy_r <= 1'b1;
			idx_r <= idx_i;
			wait_r <= {idx_i[1:0], 2'h0};
		end
		else if (busy_r && wait_r == 4'h0)
		begin
			ack_o <= 1'b1;
			busy_r <= 1'b0;
			entry_o <= {1'b0, idx_r, 2'h0, idx_r[2:0], 1'b0, idx_r[6:0],
				{6{idx_r[7:0]}}};
		end
		else if (busy_r)
			wait_r <= wait_r - 4'h1;
	end
endmodule : iaw_tbl_model
